/* File: verilog/orientation_detect_engine.sv */
/*
 orientation engine: classifies samples into portrait/landscape and up/down,
 applies blocking, raises an event on status change except the silent vertical bit clear.
 assumes sample_valid is a one-cycle strobe from same-clock data logic.
*/
// What this block does
// - two-bit mode picks threshold set
// - classify from eight-bit truncated samples
// - hysteresis margin on every classification condition
// - symmetrical mode compares |y| against |x|
// - high mode uses twice |x|
// - low mode uses half |x|
// - vertical hysteresis 205 LSB, range scaled
// - z above +hyst upside, below downside
// - vertical bit also computed for flat
// - select 01 blocks horizontal or 1.5g
// - select 10 adds slope 0.2g blocking
// - select 11 slope 0.4g plus 100ms stability
// - slope block lifts after three quiet samples
// - timer restarts on any orientation change
// - horizontal when angle times z-squared dominates
// - axes clipped to six bits at 1g
// - scale samples up to 2g range
// - event on each status code change except the vertical bit clear
// - vertical bit counted only when enabled
// - status updates only when event allowed, save vertical bit clear when disabled
// - swap x and z for orientation, vertical bit and blocking
// - keep right-handed axes after swap
`timescale 1ns/1ps
module orientation_detect_engine #(
  parameter int unsigned STABLE_CYCLES = orient_pkg::STABLE_CYCLES
) (
  input  wire logic               clock,
  input  wire logic               nrst,
  input  wire logic               sample_valid,
  input  wire logic signed [15:0] acc_x,
  input  wire logic signed [15:0] acc_y,
  input  wire logic signed [15:0] acc_z,
  input  wire logic [1:0]         range_select,
  input  wire logic [1:0]         orient_mode,
  input  wire logic [1:0]         blocking_select,
  input  wire logic [5:0]         hysteresis,
  input  wire logic [5:0]         blocking_angle,
  input  wire logic               vertical_bit_enable,
  input  wire logic               flat_enable,
  input  wire logic               axis_swap_select,
  output logic [2:0]              orient_status,
  output logic                    orient_event,
  output logic                    vertical_status
);
  axis_if bus ();

  logic signed [15:0] sx;
  logic signed [15:0] sy;
  logic signed [15:0] sz;
  logic [3:0]         shift;

  // swap and range scaling
  always_comb begin
    shift = 4'h0;
    case (range_select)
      orient_pkg::RANGE_4G: shift = 4'h1;
      orient_pkg::RANGE_8G: shift = 4'h2;
      orient_pkg::RANGE_2G: shift = 4'h0;
      default:              shift = 4'h3;
    endcase
    if (axis_swap_select) begin
      sx = 16'(-acc_z);
      sy = acc_y;
      sz = acc_x;
    end else begin
      sx = acc_x;
      sy = acc_y;
      sz = acc_z;
    end
  end

  function automatic logic signed [15:0] amp(input logic signed [15:0] v, input logic [3:0] s);
    logic signed [18:0] w;
    w = 19'(v) <<< s;
    if (w > 19'sh07FFF) amp = 16'sh7FFF;
    else if (w < -19'sh08000) amp = 16'sh8000;
    else amp = w[15:0];
  endfunction : amp

  assign bus.ax        = amp(sx, shift);
  assign bus.ay        = amp(sy, shift);
  assign bus.az        = amp(sz, shift);
  assign bus.sample    = sample_valid;
  assign bus.blk_angle = blocking_angle;

  horizon_check u_horz (
    .bus (bus)
  );

  stable_timer #(
    .STABLE_CYCLES (STABLE_CYCLES)
  ) u_tmr (
    .clock (clock),
    .nrst  (nrst),
    .bus   (bus)
  );

  // eight-bit classification
  logic signed [7:0] tx;
  logic signed [7:0] ty;
  logic [8:0]        mx;
  logic [8:0]        my;
  logic [9:0]        lim_land;
  logic [9:0]        lim_port;
  logic              is_land;
  logic              is_port;
  logic [1:0]        pl_code;
  logic [1:0]        pl_ff;
  logic              up_ff;
  logic              nxt_up;
  logic [15:0]       zhyst;

  always_comb begin
    tx = sx[15:8];
    ty = sy[15:8];
    mx = tx[7] ? 9'(-10'(tx)) : 9'(tx);
    my = ty[7] ? 9'(-10'(ty)) : 9'(ty);
    lim_land = 10'h000;
    lim_port = 10'h3FF;
    case (orient_mode)
      orient_pkg::MODE_HIGH: begin
        if (mx > 9'(hysteresis)) lim_land = 10'((mx - 9'(hysteresis)) << 1);
        lim_port = 10'(mx << 1) + 10'(hysteresis);
      end
      orient_pkg::MODE_LOW: begin
        if (mx > 9'(hysteresis)) lim_land = 10'((mx - 9'(hysteresis)) >> 1);
        lim_port = 10'(mx >> 1) + 10'(hysteresis);
      end
      default: begin
        if (mx > 9'(hysteresis)) lim_land = 10'(mx - 9'(hysteresis));
        lim_port = 10'(mx) + 10'(hysteresis);
      end
    endcase
    is_land = 10'(my) < lim_land;
    is_port = 10'(my) > lim_port;
    if (is_land) pl_code = tx[7] ? 2'h1 : 2'h0;
    else if (is_port) pl_code = ty[7] ? 2'h2 : 2'h3;
    else pl_code = pl_ff;
  end

  // vertical bit with fixed hysteresis
  always_comb begin
    zhyst = orient_pkg::VERT_HYST_2G;
    nxt_up = up_ff;
    if (sz > $signed(zhyst)) nxt_up = 1'b0;
    else if (sz < -$signed(zhyst)) nxt_up = 1'b1;
  end

  // sign-sensitive vertical decision uses scaled z against fixed hyst
  logic signed [15:0] sz_scaled;
  assign sz_scaled = bus.az;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pl_ff <= 2'h0;
      up_ff <= 1'b0;
    end else if (sample_valid) begin
      pl_ff <= pl_code;
      if (vertical_bit_enable || flat_enable) begin
        if (sz_scaled > $signed(zhyst)) up_ff <= 1'b0;
        else if (sz_scaled < -$signed(zhyst)) up_ff <= 1'b1;
        else up_ff <= nxt_up;
      end
    end
  end

  assign bus.code = {vertical_bit_enable & up_ff, pl_ff};

  // blocking conditions
  logic signed [15:0] px_ff;
  logic signed [15:0] py_ff;
  logic signed [15:0] pz_ff;
  logic               high_g;
  logic               slope_hit;
  logic [15:0]        slope_thr;
  logic [1:0]         hit_run_ff;
  logic [1:0]         quiet_run_ff;
  logic               slope_blk_ff;

  function automatic logic [15:0] mag(input logic signed [15:0] v);
    mag = v[15] ? 16'(-v) : 16'(v);
  endfunction : mag

  function automatic logic [15:0] dif(input logic signed [15:0] a, input logic signed [15:0] b);
    logic signed [16:0] d;
    d = 17'(a) - 17'(b);
    dif = d[16] ? 16'(-d) : d[15:0];
  endfunction : dif

  always_comb begin
    high_g = (mag(bus.ax) > orient_pkg::HIGH_G_2G) || (mag(bus.ay) > orient_pkg::HIGH_G_2G)
          || (mag(bus.az) > orient_pkg::HIGH_G_2G);
    slope_thr = (blocking_select == orient_pkg::BLK_FULL) ? orient_pkg::SLOPE_HI_2G
                                                         : orient_pkg::SLOPE_LO_2G;
    slope_hit = (dif(bus.ax, px_ff) > slope_thr) || (dif(bus.ay, py_ff) > slope_thr)
             || (dif(bus.az, pz_ff) > slope_thr);
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      px_ff        <= 16'sh0000;
      py_ff        <= 16'sh0000;
      pz_ff        <= 16'sh0000;
      hit_run_ff   <= 2'h0;
      quiet_run_ff <= 2'h0;
      slope_blk_ff <= 1'b0;
    end else if (sample_valid) begin
      px_ff <= bus.ax;
      py_ff <= bus.ay;
      pz_ff <= bus.az;
      if (slope_hit) begin
        quiet_run_ff <= 2'h0;
        if (hit_run_ff == 2'(orient_pkg::SLOPE_RUN - 1)) slope_blk_ff <= 1'b1;
        else hit_run_ff <= hit_run_ff + 2'h1;
      end else begin
        hit_run_ff <= 2'h0;
        if (quiet_run_ff == 2'(orient_pkg::SLOPE_RUN - 1)) slope_blk_ff <= 1'b0;
        else quiet_run_ff <= quiet_run_ff + 2'h1;
      end
    end
  end

  logic blocked;
  always_comb begin
    case (blocking_select)
      orient_pkg::BLK_NONE:  blocked = 1'b0;
      orient_pkg::BLK_BASIC: blocked = bus.horizontal || high_g;
      orient_pkg::BLK_SLOPE: blocked = bus.horizontal || high_g || slope_blk_ff;
      orient_pkg::BLK_FULL:  blocked = bus.horizontal || high_g || slope_blk_ff || !bus.stable;
      default:               blocked = 1'b0;
    endcase
  end

  // status update and event
  logic pending_ff;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      orient_status <= orient_pkg::CODE_RESET;
      orient_event  <= 1'b0;
      pending_ff    <= 1'b0;
    end else begin
      orient_event <= 1'b0;
      pending_ff   <= sample_valid;
      if (pending_ff && bus.code != orient_status && !blocked) begin
        orient_status <= bus.code;
        orient_event  <= 1'b1;
      end else if (!vertical_bit_enable) begin
        orient_status[orient_pkg::CODE_VERT_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) vertical_status <= 1'b0;
    else vertical_status <= up_ff;
  end
endmodule : orientation_detect_engine

/* File: verilog/orient_pkg.sv */
/*
 orientation engine package: mode codes, field layout, thresholds, timing.
 assumes 50 MHz clock and 16-bit signed acceleration samples.
*/
package orient_pkg;
  localparam int unsigned CLK_HZ          = 50000000;
  localparam int unsigned STABLE_MS       = 100;
  localparam int unsigned STABLE_CYCLES   = CLK_HZ / 1000 * STABLE_MS;
  localparam int unsigned TRUNC_W         = 8;
  localparam int unsigned SAT_W           = 6;
  localparam int unsigned PROD_W          = 10;
  localparam int unsigned SLOPE_RUN       = 3;
  localparam logic [15:0] VERT_HYST_2G    = 16'h00CD;
  localparam logic [15:0] HIGH_G_2G       = 16'h6000;
  localparam logic [15:0] SLOPE_LO_2G     = 16'h0CCD;
  localparam logic [15:0] SLOPE_HI_2G     = 16'h199A;
  localparam logic [15:0] ONE_G_2G        = 16'h4000;
  localparam logic [1:0]  MODE_HIGH       = 2'h1;
  localparam logic [1:0]  MODE_LOW        = 2'h2;
  localparam logic [1:0]  BLK_NONE        = 2'h0;
  localparam logic [1:0]  BLK_BASIC       = 2'h1;
  localparam logic [1:0]  BLK_SLOPE       = 2'h2;
  localparam logic [1:0]  BLK_FULL        = 2'h3;
  localparam logic [1:0]  RANGE_2G        = 2'h0;
  localparam logic [1:0]  RANGE_4G        = 2'h1;
  localparam logic [1:0]  RANGE_8G        = 2'h2;
  localparam int unsigned CODE_VERT_BIT   = 2;
  localparam logic [2:0]  CODE_RESET      = 3'h0;
  typedef enum logic [1:0] {
    tmr_idle = 2'b00,
    tmr_run  = 2'b01,
    tmr_done = 2'b10
  } tmr_state_t;
endpackage : orient_pkg

/* File: verilog/axis_if.sv */
/*
 carrier between the orientation top and its helpers: scaled axes and flags.
 assumes one clock domain.
*/
`timescale 1ns/1ps
interface axis_if;
  logic signed [15:0] ax;
  logic signed [15:0] ay;
  logic signed [15:0] az;
  logic               sample;
  logic [5:0]         blk_angle;
  logic               horizontal;
  logic [2:0]         code;
  logic               stable;
  modport top  (output ax, output ay, output az, output sample, output blk_angle, output code,
                input horizontal, input stable);
  modport horz (input ax, input ay, input az, input blk_angle, output horizontal);
  modport tmr  (input sample, input code, output stable);
endinterface : axis_if

/* File: verilog/horizon_check.sv */
/*
 near-horizontal test on clipped 6-bit magnitudes.
 assumes axes already swapped and scaled to the 2 g range.
*/
`timescale 1ns/1ps
module horizon_check (
  axis_if.horz bus
);
  function automatic logic [5:0] clip6(input logic signed [15:0] v);
    logic [15:0] m;
    m = v[15] ? 16'(-v) : 16'(v);
    if (m >= orient_pkg::ONE_G_2G) clip6 = 6'h3F;
    else clip6 = m[13:8];
  endfunction : clip6

  logic [5:0]  clipped_magnitude_x;
  logic [5:0]  clipped_magnitude_y;
  logic [5:0]  clipped_magnitude_z;
  logic [11:0] zz;
  logic [11:0] xx;
  logic [11:0] yy;
  logic [11:0] lhs;
  logic [10:0] rhs;

  always_comb begin
    clipped_magnitude_x = clip6(bus.ax);
    clipped_magnitude_y = clip6(bus.ay);
    clipped_magnitude_z = clip6(bus.az);
    zz  = 12'(clipped_magnitude_z) * 12'(clipped_magnitude_z);
    xx  = 12'(clipped_magnitude_x) * 12'(clipped_magnitude_x);
    yy  = 12'(clipped_magnitude_y) * 12'(clipped_magnitude_y);
    lhs = 12'(bus.blk_angle) * 12'(zz[11:6]);
    rhs = 11'(xx[11:2]) + 11'(yy[11:2]);
    bus.horizontal = ({1'b0, lhs[11:2]} > rhs);
  end
endmodule : horizon_check

/* File: verilog/stable_timer.sv */
/*
 stability timer: restarts on each code change, reports expiry.
 assumes sample is a one-cycle strobe per classified sample.
*/
`timescale 1ns/1ps
module stable_timer #(
  parameter int unsigned STABLE_CYCLES = orient_pkg::STABLE_CYCLES
) (
  input  wire logic clock,
  input  wire logic nrst,
  axis_if.tmr       bus
);
  orient_pkg::tmr_state_t state_ff;
  logic [22:0]            cnt_ff;
  logic [2:0]             last_ff;
  logic                   code_moved;

  // code moves one cycle after its sample; block in that very cycle
  assign code_moved = (bus.code != last_ff);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_ff <= orient_pkg::tmr_done;
      cnt_ff   <= 23'h000000;
      last_ff  <= orient_pkg::CODE_RESET;
    end else begin
      last_ff <= bus.code;
      if (code_moved) begin
        state_ff <= orient_pkg::tmr_run;
        cnt_ff   <= 23'h000000;
      end else begin
        case (state_ff)
          orient_pkg::tmr_run: begin
            if (cnt_ff >= 23'(STABLE_CYCLES - 1)) state_ff <= orient_pkg::tmr_done;
            else cnt_ff <= cnt_ff + 23'h000001;
          end
          orient_pkg::tmr_idle: state_ff <= orient_pkg::tmr_done;
          default: state_ff <= orient_pkg::tmr_done;
        endcase
      end
    end
  end

  assign bus.stable = (state_ff == orient_pkg::tmr_done) && !code_moved;
endmodule : stable_timer

/* File: testbench/orient_checker_asserts.sv */
/*
 port checker for the orientation engine.
 assumes 2 g scaled 16-bit samples and a two-cycle answer after each sample.
*/
`timescale 1ns/1ps
module orient_checker #(
  parameter int unsigned STABLE_CYCLES = orient_pkg::STABLE_CYCLES
) (
  input wire logic               clock,
  input wire logic               nrst,
  input wire logic               sample_valid,
  input wire logic signed [15:0] acc_x,
  input wire logic signed [15:0] acc_y,
  input wire logic signed [15:0] acc_z,
  input wire logic [1:0]         range_select,
  input wire logic [1:0]         orient_mode,
  input wire logic [1:0]         blocking_select,
  input wire logic               vertical_bit_enable,
  input wire logic               axis_swap_select,
  input wire logic [2:0]         orient_status,
  input wire logic               orient_event
);
  logic [1:0] sv_ff;
  logic [1:0] plain_ff;
  logic       plain;
  // no blocking, 2 g range, symmetrical mode
  assign plain = (blocking_select == orient_pkg::BLK_NONE) && (range_select == orient_pkg::RANGE_2G)
                 && (orient_mode == 2'h0);
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sv_ff    <= 2'h0;
      plain_ff <= 2'h0;
    end else begin
      sv_ff    <= {sv_ff[0], sample_valid};
      plain_ff <= {plain_ff[0], plain};
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  a_event_on_change: assert property (
    orient_event |-> orient_status != $past(orient_status)) else $error("event without status change");
  a_status_needs_event: assert property (
    orient_status != $past(orient_status) |-> orient_event) else $error("status moved silently");
  a_event_after_sample: assert property (
    orient_event |-> sv_ff[1]) else $error("event not two cycles after a sample");
  a_vert_bit_masked: assert property (
    orient_event && !vertical_bit_enable && !$past(vertical_bit_enable) |-> !orient_status[2])
    else $error("vertical bit set while disabled");
  a_high_g_blocks: assert property (
    sv_ff[1] && $past(blocking_select, 2) != orient_pkg::BLK_NONE && $past(range_select, 2) == orient_pkg::RANGE_2G
    && $past(acc_y, 2) > 16'sh6000 |-> !orient_event) else $error("event above 1.5 g");
  a_sym_portrait: assert property (
    sv_ff[1] && plain_ff[1] && !$past(axis_swap_select, 2) && $past(acc_x[15:8], 2) == 8'h00
    && $past(acc_y, 2) >= 16'sh4000 |-> orient_status[1:0] == 2'h3) else $error("portrait upright missed");
  a_downside_bit: assert property (
    sv_ff[1] && plain_ff[1] && vertical_bit_enable && $past(vertical_bit_enable, 2) && !$past(axis_swap_select, 2)
    && $past(acc_z, 2) < -16'sh3F00 |-> orient_status[2]) else $error("downside missed");
  a_swap_axes: assert property (
    sv_ff[1] && plain_ff[1] && $past(axis_swap_select, 2) && $past(acc_y[15:8], 2) == 8'h00
    && $past(acc_z, 2) >= 16'sh4000 |-> orient_status[1:0] == 2'h1) else $error("swap not applied");
endmodule : orient_checker

bind orientation_detect_engine orient_checker #(.STABLE_CYCLES(STABLE_CYCLES)) i_chk (
  .clock(clock), .nrst(nrst), .sample_valid(sample_valid), .acc_x(acc_x), .acc_y(acc_y), .acc_z(acc_z),
  .range_select(range_select), .orient_mode(orient_mode), .blocking_select(blocking_select),
  .vertical_bit_enable(vertical_bit_enable), .axis_swap_select(axis_swap_select),
  .orient_status(orient_status), .orient_event(orient_event));

/* File: testbench/orientation_detect_engine_tb.sv */
/*
 self-checking bench for the orientation engine.
 assumes a shortened stability timer of 50 cycles.
*/
`timescale 1ns/1ps
module orientation_detect_engine_tb;
  localparam logic signed [15:0] G = 16'sh4000;
  localparam logic signed [15:0] P = 16'sh0200;
  logic               clock = 1'b0;
  logic               nrst = 1'b0;
  logic               sample_valid = 1'b0;
  logic signed [15:0] acc_x = 16'h0000;
  logic signed [15:0] acc_y = 16'h0000;
  logic signed [15:0] acc_z = 16'h0000;
  logic [1:0]         range_select = 2'h0;
  logic [1:0]         orient_mode = 2'h0;
  logic [1:0]         blocking_select = 2'h0;
  logic [5:0]         hysteresis = 6'h04;
  logic [5:0]         blocking_angle = 6'h08;
  logic               vertical_bit_enable = 1'b0;
  logic               flat_enable = 1'b1;
  logic               axis_swap_select = 1'b0;
  logic [2:0]         orient_status;
  logic               orient_event;
  logic               vertical_status;
  logic [2:0]         exp_q[$];
  logic [2:0]         cur = 3'h0;
  logic [2:0]         a_tab[4] = '{3'h3, 3'h0, 3'h3, 3'h3};
  logic [2:0]         b_tab[4] = '{3'h0, 3'h0, 3'h3, 3'h0};
  int                 error_cnt = 0;
  int                 total_checks = 0;
  int                 ev_cnt = 0;
  int                 seed = 72;
  int                 base;

  orientation_detect_engine #(.STABLE_CYCLES(50)) i_dut (
    .clock(clock), .nrst(nrst), .sample_valid(sample_valid), .acc_x(acc_x), .acc_y(acc_y), .acc_z(acc_z),
    .range_select(range_select), .orient_mode(orient_mode), .blocking_select(blocking_select),
    .hysteresis(hysteresis), .blocking_angle(blocking_angle), .vertical_bit_enable(vertical_bit_enable),
    .flat_enable(flat_enable), .axis_swap_select(axis_swap_select), .orient_status(orient_status),
    .orient_event(orient_event), .vertical_status(vertical_status));

  always #10 clock = ~clock;

  task check(input logic [15:0] seen, input logic [15:0] expd);
    total_checks++;
    if (seen !== expd) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, expd);
    end
  endtask : check

  task report_and_stop;
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop

  // one sample with random low bits, noting the status it should bring
  task send(input logic signed [15:0] x, input logic signed [15:0] y, input logic signed [15:0] z,
            input logic [2:0] code);
    @(negedge clock);
    sample_valid = 1'b1;
    acc_x = x | 16'($random(seed) & 255);
    acc_y = y | 16'($random(seed) & 255);
    acc_z = z | 16'($random(seed) & 255);
    if (code != cur) begin
      exp_q.push_back(code);
      cur = code;
    end
    @(negedge clock);
    sample_valid = 1'b0;
    repeat (3) @(negedge clock);
    if (!axis_swap_select && z[15] != z[14]) check(16'(vertical_status), 16'(z[15]));
  endtask : send

  // result watcher
  always @(negedge clock) begin
    if (orient_event === 1'b1) begin
      ev_cnt++;
      if (exp_q.size() > 0) check(16'(orient_status), 16'(exp_q.pop_front()));
      else check(16'(orient_status), 16'hFFFF);
    end
  end

  initial begin
    #100000;
    error_cnt++;
    report_and_stop();
  end

  initial begin
    repeat (4) @(negedge clock);
    nrst = 1'b1;
    send(-G, 0, G, 3'h1);
    send(0, -G, G, 3'h2);
    send(0, G, -G, 3'h3);
    send(G, 0, -G, 3'h0);
    send(G, 16'sh4200, G, 3'h0);
    for (int m = 0; m < 4; m++) begin
      orient_mode = 2'(m);
      send(G, 16'sh6000, G, a_tab[m]);
      send(16'sh6000, G, G, b_tab[m]);
    end
    orient_mode = 2'h0;
    axis_swap_select = 1'b1;
    send(0, 0, G, 3'h1);
    axis_swap_select = 1'b0;
    vertical_bit_enable = 1'b1;
    send(-G, 0, -G, 3'h5);
    send(-G, 0, -16'sh0100, 3'h5);
    send(-G, 0, P, 3'h1);
    range_select = 2'h1;
    send(0, -16'sh2000, 16'sh2000, 3'h2);
    range_select = 2'h0;
    blocking_select = 2'h1;
    send(-G, 16'sh7000, 0, 3'h2);
    blocking_angle = 6'h3F;
    send(-16'sh0800, 0, G, 3'h2);
    blocking_angle = 6'h08;
    send(-G, 0, P, 3'h1);
    blocking_select = 2'h2;
    send(-G, 0, G, 3'h1);
    send(-G, 0, P, 3'h1);
    send(-G, 0, G, 3'h1);
    base = ev_cnt;
    repeat (3) send(G, 0, P, 3'h0);
    check(16'(ev_cnt), 16'(base));
    repeat (2) send(G, 0, P, 3'h0);
    check(16'(exp_q.size()), 16'h0000);
    blocking_select = 2'h3;
    base = ev_cnt;
    repeat (7) send(0, G, P, 3'h3);
    check(16'(ev_cnt), 16'(base));
    repeat (6) send(0, G, P, 3'h3);
    check(16'(exp_q.size()), 16'h0000);
    report_and_stop();
  end
endmodule : orientation_detect_engine_tb
